// file: rtl/wesp_port.sv
/*
  wesp_port: AXI4-Lite register slave and single-word waveform engine that
  masters a 16-bit bus to an external synchronous FIFO. Assumes pins and the
  external clock are asynchronous and are synchronised here.
*/
// Behaviour
// - slot register stores a 2-bit value that reads back; the engine does not use it.
// - clock source bit 1 selects internal interface clock, 0 external clock.
// - frequency bit 1 gives 48 MHz internal clock, else lower rate.
// - clock output enable bit drives interface clock onto clock pin.
// - clock polarity bit inverts driven interface clock.
// - sync select bit ignored in engine mode; always clock-referenced.
// - debug enable bit shows engine state on three debug pins.
// - mode field 10 selects engine mode, else plain port mode.
// - write to low trigger register launches single-word write.
// - high register byte goes on bus 7:0, trigger byte on 15:8.
// - done flag bit 7 of trigger register reads 1 when idle.
// - read of read-trigger register launches single-word read, returns dummy.
// - captured word held in high and quiet low registers; reads start nothing.
// - ready-status register shows live ready inputs, bit1 space, bit0 data.
// - write steps states 0,1 then idle; data and strobe in state 0.
// - read steps states 0,1,2 then idle; samples bus at state 2 end.
`timescale 1ns/1ps
`default_nettype none
module wesp_port (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic i_ext_clk,
  input wire logic [15:0] i_bus_data,
  output logic [15:0] o_bus_data,
  output logic o_bus_data_oe,
  output logic o_write_strobe_n,
  output logic o_read_enable_n,
  output logic o_output_enable_n,
  input wire logic i_fifo_has_space,
  input wire logic i_fifo_has_data,
  output logic o_if_clk,
  output logic o_if_clk_oe,
  output logic [2:0] o_state_debug,
  output logic o_port_mode,
  output logic o_irq
);
  logic [7:0] cfg_ff, nxt_cfg;
  logic [7:0] dhi_ff, nxt_dhi;
  logic [7:0] dlo_ff, nxt_dlo;
  logic [1:0] slot_ff, nxt_slot;
  logic [1:0] ists_ff, nxt_ists;
  logic [1:0] ien_ff, nxt_ien;
  logic aw_ff, nxt_aw, w_ff, nxt_w;
  logic [7:0] awa_ff, nxt_awa;
  logic [31:0] wd_ff, nxt_wd;
  logic [3:0] ws_ff, nxt_ws;
  logic bv_ff, nxt_bv, rv_ff, nxt_rv;
  logic [1:0] br_ff, nxt_br, rr_ff, nxt_rr;
  logic [31:0] rd_ff, nxt_rd;
  wesp_pkg::wesp_state_e st_ff, nxt_st;
  logic is_rd_ff, nxt_is_rd;
  logic [15:0] dout_ff, nxt_dout;
  logic [2:0] ext_sync_ff, sp_sync_ff, dt_sync_ff;
  logic [15:0] bus_s1_ff, bus_s2_ff;
  logic int_tick, int_level, ext_tick, if_tick, if_level;
  logic engine_mode, idle, wr_go, rd_go, wr_fire, rd_fire;

  // sync of external clock, ready and bus pins; only stage 2 onward is read
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      ext_sync_ff <= 3'h0;
      sp_sync_ff <= 3'h0;
      dt_sync_ff <= 3'h0;
      bus_s1_ff <= 16'h0000;
      bus_s2_ff <= 16'h0000;
    end
    else
    begin
      ext_sync_ff <= {ext_sync_ff[1:0], i_ext_clk};
      sp_sync_ff <= {sp_sync_ff[1:0], i_fifo_has_space};
      dt_sync_ff <= {dt_sync_ff[1:0], i_fifo_has_data};
      bus_s1_ff <= i_bus_data;
      bus_s2_ff <= bus_s1_ff;
    end
  end

  wesp_clk_gen u_clk_gen (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_fast(cfg_ff[wesp_pkg::CFG_FREQ_SEL]),
    .o_tick(int_tick),
    .o_level(int_level)
  );

  assign ext_tick = ext_sync_ff[1] & ~ext_sync_ff[2];
  // source select; sync bit plays no part
  assign if_tick = cfg_ff[wesp_pkg::CFG_CLK_SRC] ? int_tick : ext_tick;
  assign if_level = cfg_ff[wesp_pkg::CFG_CLK_SRC] ? int_level : ext_sync_ff[2];
  assign engine_mode = (cfg_ff[1:0] == wesp_pkg::MODE_ENGINE);
  assign idle = (st_ff == wesp_pkg::WESP_IDLE);

  // axi write path
  assign s_axi_awready = ~aw_ff & ~bv_ff;
  assign s_axi_wready = ~w_ff & ~bv_ff;
  assign wr_go = aw_ff & w_ff & ~bv_ff;
  assign rd_go = s_axi_arvalid & s_axi_arready;
  assign s_axi_arready = ~rv_ff;
  assign wr_fire = wr_go & (awa_ff == wesp_pkg::OFS_DATA_LOW_TRIG) & ws_ff[0]
    & idle & engine_mode;
  assign rd_fire = rd_go & (s_axi_araddr == wesp_pkg::OFS_DATA_READ_TRIG)
    & idle & engine_mode & ~wr_fire;

  always_comb
  begin
    nxt_aw = aw_ff;
    nxt_w = w_ff;
    nxt_awa = awa_ff;
    nxt_wd = wd_ff;
    nxt_ws = ws_ff;
    nxt_bv = bv_ff;
    nxt_br = br_ff;
    nxt_cfg = cfg_ff;
    nxt_dhi = dhi_ff;
    nxt_dlo = dlo_ff;
    nxt_slot = slot_ff;
    nxt_ien = ien_ff;
    nxt_ists = ists_ff;
    if (s_axi_awvalid & s_axi_awready)
    begin
      nxt_aw = 1'b1;
      nxt_awa = {s_axi_awaddr[7:2], 2'b00};
    end
    if (s_axi_wvalid & s_axi_wready)
    begin
      nxt_w = 1'b1;
      nxt_wd = s_axi_wdata;
      nxt_ws = s_axi_wstrb;
    end
    if (bv_ff & s_axi_bready)
      nxt_bv = 1'b0;
    if (wr_go)
    begin
      nxt_aw = 1'b0;
      nxt_w = 1'b0;
      nxt_bv = 1'b1;
      nxt_br = 2'b00;
      case (awa_ff)
        wesp_pkg::OFS_IF_CONFIG:
        begin
          if (ws_ff[0])
            nxt_cfg = wd_ff[7:0];
        end
        wesp_pkg::OFS_DATA_HIGH:
        begin
          if (ws_ff[0])
            nxt_dhi = wd_ff[7:0];
        end
        wesp_pkg::OFS_DATA_LOW_TRIG, wesp_pkg::OFS_DATA_LOW_QUIET:
        begin
          if (ws_ff[0])
            nxt_dlo = wd_ff[7:0];
        end
        wesp_pkg::OFS_WAVE_SLOT:
        begin
          if (ws_ff[0])
            nxt_slot = wd_ff[1:0];
        end
        wesp_pkg::OFS_IRQ_ENABLE:
        begin
          if (ws_ff[0])
            nxt_ien = wd_ff[1:0];
        end
        wesp_pkg::OFS_IRQ_CLEAR:
        begin
          if (ws_ff[0])
            nxt_ists = ists_ff & ~wd_ff[1:0];
        end
        wesp_pkg::OFS_TRIGGER, wesp_pkg::OFS_DATA_READ_TRIG,
        wesp_pkg::OFS_READY_STATUS, wesp_pkg::OFS_IRQ_STATUS: nxt_br = 2'b00;
        default: nxt_br = 2'b10;
      endcase
    end
    // capture completed read word
    if (is_rd_ff & (st_ff == wesp_pkg::WESP_S2) & if_tick)
    begin
      nxt_dhi = bus_s2_ff[7:0];
      nxt_dlo = bus_s2_ff[15:8];
    end
    // set beats clear
    if (if_tick & ~idle & (st_ff == wesp_pkg::WESP_S1) & ~is_rd_ff)
      nxt_ists[wesp_pkg::IRQ_WR_DONE] = 1'b1;
    if (if_tick & (st_ff == wesp_pkg::WESP_S2))
      nxt_ists[wesp_pkg::IRQ_RD_DONE] = 1'b1;
  end

  // axi read path
  always_comb
  begin
    nxt_rv = rv_ff;
    nxt_rd = rd_ff;
    nxt_rr = rr_ff;
    if (rv_ff & s_axi_rready)
      nxt_rv = 1'b0;
    if (rd_go)
    begin
      nxt_rv = 1'b1;
      nxt_rr = 2'b00;
      nxt_rd = 32'h0000_0000;
      case ({s_axi_araddr[7:2], 2'b00})
        wesp_pkg::OFS_IF_CONFIG: nxt_rd[7:0] = cfg_ff;
        wesp_pkg::OFS_TRIGGER: nxt_rd[wesp_pkg::TRIG_DONE_BIT] = idle;
        wesp_pkg::OFS_DATA_HIGH: nxt_rd[7:0] = dhi_ff;
        wesp_pkg::OFS_DATA_LOW_TRIG: nxt_rd[7:0] = dlo_ff;
        wesp_pkg::OFS_DATA_LOW_QUIET: nxt_rd[7:0] = dlo_ff;
        wesp_pkg::OFS_DATA_READ_TRIG: nxt_rd = 32'h0000_0000; // dummy
        wesp_pkg::OFS_READY_STATUS: nxt_rd[1:0] = {sp_sync_ff[2], dt_sync_ff[2]};
        wesp_pkg::OFS_IRQ_STATUS: nxt_rd[1:0] = ists_ff;
        wesp_pkg::OFS_IRQ_ENABLE: nxt_rd[1:0] = ien_ff;
        wesp_pkg::OFS_IRQ_CLEAR: nxt_rd = 32'h0000_0000;
        wesp_pkg::OFS_WAVE_SLOT: nxt_rd[1:0] = slot_ff;
        default: nxt_rr = 2'b10;
      endcase
    end
  end

  // waveform engine
  always_comb
  begin
    nxt_st = st_ff;
    nxt_is_rd = is_rd_ff;
    nxt_dout = dout_ff;
    if (wr_fire)
    begin
      nxt_st = wesp_pkg::WESP_S0; // done drops here
      nxt_is_rd = 1'b0;
      nxt_dout = {wd_ff[7:0], dhi_ff};
    end
    else if (rd_fire)
    begin
      nxt_st = wesp_pkg::WESP_S0;
      nxt_is_rd = 1'b1;
    end
    else if (if_tick)
    begin
      case (st_ff)
        wesp_pkg::WESP_S0: nxt_st = wesp_pkg::WESP_S1;
        wesp_pkg::WESP_S1:
          nxt_st = is_rd_ff ? wesp_pkg::WESP_S2 : wesp_pkg::WESP_IDLE;
        wesp_pkg::WESP_S2: nxt_st = wesp_pkg::WESP_IDLE; // word taken on this tick
        default: nxt_st = wesp_pkg::WESP_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      cfg_ff <= wesp_pkg::CFG_RESET;
      dhi_ff <= 8'h00;
      dlo_ff <= 8'h00;
      slot_ff <= 2'h0;
      ists_ff <= 2'h0;
      ien_ff <= 2'h0;
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      awa_ff <= 8'h00;
      wd_ff <= 32'h0000_0000;
      ws_ff <= 4'h0;
      bv_ff <= 1'b0;
      br_ff <= 2'h0;
      rv_ff <= 1'b0;
      rr_ff <= 2'h0;
      rd_ff <= 32'h0000_0000;
      st_ff <= wesp_pkg::WESP_IDLE;
      is_rd_ff <= 1'b0;
      dout_ff <= 16'h0000;
    end
    else
    begin
      cfg_ff <= nxt_cfg;
      dhi_ff <= nxt_dhi;
      dlo_ff <= nxt_dlo;
      slot_ff <= nxt_slot;
      ists_ff <= nxt_ists;
      ien_ff <= nxt_ien;
      aw_ff <= nxt_aw;
      w_ff <= nxt_w;
      awa_ff <= nxt_awa;
      wd_ff <= nxt_wd;
      ws_ff <= nxt_ws;
      bv_ff <= nxt_bv;
      br_ff <= nxt_br;
      rv_ff <= nxt_rv;
      rr_ff <= nxt_rr;
      rd_ff <= nxt_rd;
      st_ff <= nxt_st;
      is_rd_ff <= nxt_is_rd;
      dout_ff <= nxt_dout;
    end
  end

  // S0 of a write: strobe and data; S0 to S2 of read: read enable low
  assign o_bus_data = dout_ff;
  assign o_bus_data_oe = (st_ff == wesp_pkg::WESP_S0) & ~is_rd_ff;
  assign o_write_strobe_n = ~((st_ff == wesp_pkg::WESP_S0) & ~is_rd_ff);
  assign o_read_enable_n = ~(is_rd_ff & ~idle);
  assign o_output_enable_n = ~(is_rd_ff & ((st_ff == wesp_pkg::WESP_S1) |
    (st_ff == wesp_pkg::WESP_S2)));
  assign o_if_clk = if_level ^ cfg_ff[wesp_pkg::CFG_CLK_INV];
  assign o_if_clk_oe = cfg_ff[wesp_pkg::CFG_CLK_OE];
  assign o_state_debug = cfg_ff[wesp_pkg::CFG_DBG_EN] ? st_ff : 3'h0;
  assign o_port_mode = ~engine_mode;
  assign o_irq = |(ists_ff & ien_ff);
  assign s_axi_bvalid = bv_ff;
  assign s_axi_bresp = br_ff;
  assign s_axi_rvalid = rv_ff;
  assign s_axi_rdata = rd_ff;
  assign s_axi_rresp = rr_ff;
endmodule // wesp_port
`default_nettype wire

// file: rtl/wesp_pkg.sv
/*
  wesp_pkg: register map, field positions, reset values and timing counts
  for the single-word waveform port. Assumes a 125 MHz system clock.
*/
package wesp_pkg;
  // register byte offsets on the AXI4-Lite slave
  localparam logic [7:0] OFS_IF_CONFIG = 8'h00;
  localparam logic [7:0] OFS_TRIGGER = 8'h04;
  localparam logic [7:0] OFS_DATA_HIGH = 8'h08;
  localparam logic [7:0] OFS_DATA_LOW_TRIG = 8'h0C;
  localparam logic [7:0] OFS_DATA_LOW_QUIET = 8'h10;
  localparam logic [7:0] OFS_DATA_READ_TRIG = 8'h14;
  localparam logic [7:0] OFS_READY_STATUS = 8'h18;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h1C;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h20;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h24;
  localparam logic [7:0] OFS_WAVE_SLOT = 8'h28;
  // interface_config fields
  localparam int CFG_CLK_SRC = 7;
  localparam int CFG_FREQ_SEL = 6;
  localparam int CFG_CLK_OE = 5;
  localparam int CFG_CLK_INV = 4;
  localparam int CFG_SYNC_SEL = 3;
  localparam int CFG_DBG_EN = 2;
  localparam logic [1:0] MODE_ENGINE = 2'h2;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam int TRIG_DONE_BIT = 7;
  // interrupt bits
  localparam int IRQ_WR_DONE = 0;
  localparam int IRQ_RD_DONE = 1;
  localparam int NUM_WAVE_SLOTS = 4;
  // interface clock rates, in kHz, and system clock rate
  localparam int SYS_CLK_KHZ = 125000;
  localparam int IFC_FAST_KHZ = 48000;
  localparam int IFC_SLOW_KHZ = 30000;
  localparam int ACC_WIDTH = 18;
  // engine states
  typedef enum logic [2:0] {
    WESP_S0 = 3'b000,
    WESP_S1 = 3'b001,
    WESP_S2 = 3'b010,
    WESP_IDLE = 3'b111
  } wesp_state_e;
endpackage

// file: rtl/wesp_clk_gen.sv
/*
  wesp_clk_gen: fractional divider giving one-cycle interface clock enables
  and a square clock level for output. Assumes a single system clock.
*/
`timescale 1ns/1ps
`default_nettype none
module wesp_clk_gen (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_fast,
  output logic o_tick,
  output logic o_level
);
  localparam logic [17:0] ACC_MOD = 18'(wesp_pkg::SYS_CLK_KHZ / 2);
  localparam logic [17:0] INC_FAST = 18'(wesp_pkg::IFC_FAST_KHZ);
  localparam logic [17:0] INC_SLOW = 18'(wesp_pkg::IFC_SLOW_KHZ);
  logic [17:0] acc_ff, nxt_acc;
  logic half_ff, nxt_half;
  logic tick_ff, nxt_tick;
  logic [17:0] inc;
  always_comb
  begin
    inc = i_fast ? INC_FAST : INC_SLOW;
    nxt_half = half_ff;
    nxt_tick = 1'b0;
    if (acc_ff + inc >= ACC_MOD)
    begin
      nxt_acc = acc_ff + inc - ACC_MOD;
      nxt_half = ~half_ff;
      nxt_tick = ~half_ff;
    end
    else
    begin
      nxt_acc = acc_ff + inc;
    end
  end
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      acc_ff <= 18'h0_0000;
      half_ff <= 1'b0;
      tick_ff <= 1'b0;
    end
    else
    begin
      acc_ff <= nxt_acc;
      half_ff <= nxt_half;
      tick_ff <= nxt_tick;
    end
  end
  assign o_tick = tick_ff;
  assign o_level = half_ff;
endmodule // wesp_clk_gen
`default_nettype wire

// file: bench/wesp_port_properties.sv
/* wesp_port_properties: port-level checks on handshakes and bus strobes.
   Sees only wesp_port ports; bound into every instance below. */
`timescale 1ns/1ps
`default_nettype none
module wesp_port_checker (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic s_axi_arready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic o_bus_data_oe,
  input wire logic o_write_strobe_n,
  input wire logic o_read_enable_n,
  input wire logic o_output_enable_n,
  input wire logic [2:0] o_state_debug,
  input wire logic o_port_mode
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);
  property p_b_stands;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_b_stands: assert property (p_b_stands) else $error("bvalid dropped");
  property p_r_stands;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_stands: assert property (p_r_stands) else $error("rvalid dropped");
  property p_ar_refused;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_refused: assert property (p_ar_refused) else $error("ar taken early");
  property p_wr_drive;
    !o_write_strobe_n |-> o_bus_data_oe && o_state_debug == 3'h0;
  endproperty
  a_wr_drive: assert property (p_wr_drive) else $error("strobe without data");
  property p_wr_len;
    $fell(o_write_strobe_n) |-> ##[1:40] o_write_strobe_n;
  endproperty
  a_wr_len: assert property (p_wr_len) else $error("strobe too long");
  property p_oe_order;
    $fell(o_output_enable_n) |-> !o_read_enable_n && $past(!o_read_enable_n);
  endproperty
  a_oe_order: assert property (p_oe_order) else $error("oe before read");
  property p_rd_len;
    $fell(o_read_enable_n) |-> ##[3:60] $rose(o_read_enable_n);
  endproperty
  a_rd_len: assert property (p_rd_len) else $error("read length");
  property p_rd_close;
    $rose(o_read_enable_n) |-> o_output_enable_n && o_write_strobe_n;
  endproperty
  a_rd_close: assert property (p_rd_close) else $error("oe left on");
  property p_port_quiet;
    o_port_mode |-> o_write_strobe_n && o_read_enable_n && !o_bus_data_oe;
  endproperty
  a_port_quiet: assert property (p_port_quiet) else $error("port mode busy");
  property p_dbg_legal;
    o_state_debug inside {3'h0, 3'h1, 3'h2, 3'h7};
  endproperty
  a_dbg_legal: assert property (p_dbg_legal) else $error("bad state");
endmodule // wesp_port_checker
bind wesp_port wesp_port_checker u_wesp_port_checker (.i_clk_sys, .i_rst, .s_axi_arready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .o_bus_data_oe,
  .o_write_strobe_n, .o_read_enable_n, .o_output_enable_n, .o_state_debug, .o_port_mode);
`default_nettype wire

// file: bench/wesp_fifo_model.sv
/* wesp_fifo_model: behavioural external synchronous FIFO.
   Expects the port's active-low strobes, sampled on the system clock. */
`timescale 1ns/1ps
`default_nettype none
module wesp_fifo_model #(
  parameter int DEPTH = 4
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic [15:0] i_data,
  input wire logic i_data_oe,
  input wire logic i_write_strobe_n,
  input wire logic i_read_enable_n,
  input wire logic i_output_enable_n,
  output logic [15:0] o_data,
  output logic o_has_space,
  output logic o_has_data,
  output logic [15:0] o_last_word
);
  logic [15:0] mem [$];
  logic [15:0] wr_word;
  logic wen_d;
  logic ren_d;
  int hold;
  always @(posedge i_clk_sys)
  begin
    wen_d <= i_write_strobe_n;
    ren_d <= i_read_enable_n;
    if (i_rst)
    begin
      mem.delete();
      hold <= 0;
      o_data <= 16'h0000;
    end
    else
    begin
      if (!i_write_strobe_n)
        wr_word <= i_data_oe ? i_data : ~i_data;
      // word commits when the strobe is released
      if (i_write_strobe_n && !wen_d && mem.size() < DEPTH)
        mem.push_back(wr_word);
      if (i_write_strobe_n && !wen_d)
        o_last_word <= wr_word;
      if (i_read_enable_n && !ren_d && mem.size() > 0)
        void'(mem.pop_front());
      hold <= !i_output_enable_n ? 2 : (hold > 0 ? hold - 1 : 0);
      // released bus does not keep its value
      if (!i_output_enable_n)
        o_data <= mem.size() > 0 ? mem[0] : 16'h0000;
      else if (hold == 0)
        o_data <= ~o_data;
    end
    o_has_space <= mem.size() < DEPTH;
    o_has_data <= mem.size() > 0;
  end
endmodule // wesp_fifo_model
`default_nettype wire

// file: bench/tb_top.sv
/* tb_top: self-checking bench for wesp_port driving an external FIFO model.
   Registers reached over AXI4-Lite; map taken from wesp_pkg. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_ext_clk = 1'b0;
  logic ext_run = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [15:0] i_bus_data, o_bus_data, last_word;
  logic o_bus_data_oe, o_write_strobe_n, o_read_enable_n, o_output_enable_n;
  logic i_fifo_has_space, i_fifo_has_data, o_if_clk, o_if_clk_oe, o_port_mode, o_irq;
  logic [2:0] o_state_debug;
  logic [15:0] words [2] = '{16'h1234, 16'hBEEF};
  logic [31:0] d;
  logic [1:0] r;
  int n_mismatch = 0;
  int compares = 0;
  int cyc = 0;
  always #4 clk = ~clk;
  always #20.15 i_ext_clk = ext_run & ~i_ext_clk;
  wesp_port u_wesp_port (.i_clk_sys(clk), .i_rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .i_ext_clk, .i_bus_data, .o_bus_data,
    .o_bus_data_oe, .o_write_strobe_n, .o_read_enable_n, .o_output_enable_n, .i_fifo_has_space,
    .i_fifo_has_data, .o_if_clk, .o_if_clk_oe, .o_state_debug, .o_port_mode, .o_irq);
  wesp_fifo_model u_wesp_fifo_model (.i_clk_sys(clk), .i_rst, .i_data(o_bus_data),
    .i_data_oe(o_bus_data_oe), .i_write_strobe_n(o_write_strobe_n),
    .i_read_enable_n(o_read_enable_n), .i_output_enable_n(o_output_enable_n),
    .o_data(i_bus_data), .o_has_space(i_fifo_has_space), .o_has_data(i_fifo_has_data),
    .o_last_word(last_word));
  task automatic conclude;
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_mismatch++;
      conclude;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic aw_go;
    logic w_go;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    #1;
    while (s_axi_awvalid || s_axi_wvalid)
    begin
      aw_go = s_axi_awvalid && s_axi_awready;
      w_go = s_axi_wvalid && s_axi_wready;
      @(posedge clk);
      if (aw_go)
        s_axi_awvalid <= 1'b0;
      if (w_go)
        s_axi_wvalid <= 1'b0;
      #1;
    end
    while (!s_axi_bvalid)
    begin
      @(posedge clk);
      #1;
    end
    rs = s_axi_bresp;
    @(posedge clk);
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    #1;
    while (!s_axi_arready)
    begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    s_axi_arvalid <= 1'b0;
    #1;
    while (!s_axi_rvalid)
    begin
      @(posedge clk);
      #1;
    end
    v = s_axi_rdata;
    rs = s_axi_rresp;
    @(posedge clk);
    s_axi_rready <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [1:0] rs;
    axi_wr(a, v, rs);
    chk({30'h0000_0000, rs}, 32'h0000_0000);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] v;
    logic [1:0] rs;
    axi_rd(a, v, rs);
    chk({30'h0000_0000, rs}, 32'h0000_0000);
    chk(v & m, e);
  endtask
  task automatic wait_done;
    logic [31:0] v;
    logic [1:0] rs;
    v = 32'h0000_0000;
    while (v[wesp_pkg::TRIG_DONE_BIT] !== 1'b1)
      axi_rd(wesp_pkg::OFS_TRIGGER, v, rs);
  endtask
  task automatic clk_rate(input int exp);
    int n;
    logic p;
    n = 0;
    p = o_if_clk;
    repeat (250)
    begin
      @(posedge clk);
      #1;
      n += int'(o_if_clk && !p);
      p = o_if_clk;
    end
    compares++;
    if (n < exp - 1 || n > exp + 1)
    begin
      n_mismatch++;
      $display("[ERR] %0t interface clock edges %0d", $time, n);
    end
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    i_rst <= 1'b0;
    rd_chk(wesp_pkg::OFS_IF_CONFIG, 32'h0000_00FF, {24'h00_0000, wesp_pkg::CFG_RESET});
    rd_chk(wesp_pkg::OFS_TRIGGER, 32'h0000_0080, 32'h0000_0080);
    axi_rd(8'hFC, d, r);
    chk({30'h0000_0000, r}, 32'h0000_0002);
    axi_wr(8'hFC, 32'h0000_0000, r);
    chk({30'h0000_0000, r}, 32'h0000_0002);
    wr(wesp_pkg::OFS_IF_CONFIG, 32'h0000_00B6);
    clk_rate(60);
    wr(wesp_pkg::OFS_IF_CONFIG, 32'h0000_00F6);
    rd_chk(wesp_pkg::OFS_IF_CONFIG, 32'h0000_00FF, 32'h0000_00F6);
    clk_rate(96);
    chk({30'h0000_0000, o_if_clk_oe, o_port_mode}, 32'h0000_0002);
    chk({29'h0000_0000, o_state_debug}, {29'h0000_0000, wesp_pkg::WESP_IDLE});
    wr(wesp_pkg::OFS_WAVE_SLOT, 32'h0000_0003);
    rd_chk(wesp_pkg::OFS_WAVE_SLOT, 32'h0000_0003, 32'h0000_0003);
    wr(wesp_pkg::OFS_IRQ_ENABLE, 32'h0000_0003);
    for (int i = 0; i < 2; i++)
    begin
      wait_done;
      wr(wesp_pkg::OFS_DATA_HIGH, {24'h00_0000, words[i][7:0]});
      wr(wesp_pkg::OFS_DATA_LOW_TRIG, {24'h00_0000, words[i][15:8]});
      rd_chk(wesp_pkg::OFS_TRIGGER, 32'h0000_0080, 32'h0000_0000);
      wait_done;
      chk({16'h0000, last_word}, {16'h0000, words[i]});
    end
    #1;
    chk({31'h0000_0000, o_irq}, 32'h0000_0001);
    wr(wesp_pkg::OFS_IRQ_CLEAR, 32'h0000_0003);
    rd_chk(wesp_pkg::OFS_IRQ_STATUS, 32'h0000_0003, 32'h0000_0000);
    #1;
    chk({31'h0000_0000, o_irq}, 32'h0000_0000);
    rd_chk(wesp_pkg::OFS_READY_STATUS, 32'h0000_0003, 32'h0000_0003);
    for (int i = 0; i < 2; i++)
    begin
      wait_done;
      rd_chk(wesp_pkg::OFS_DATA_READ_TRIG, 32'hFFFF_FFFF, 32'h0000_0000);
      rd_chk(wesp_pkg::OFS_TRIGGER, 32'h0000_0080, 32'h0000_0000);
      wait_done;
      rd_chk(wesp_pkg::OFS_DATA_HIGH, 32'h0000_00FF, {24'h00_0000, words[i][7:0]});
      rd_chk(wesp_pkg::OFS_DATA_LOW_QUIET, 32'h0000_00FF, {24'h00_0000, words[i][15:8]});
      rd_chk(wesp_pkg::OFS_TRIGGER, 32'h0000_0080, 32'h0000_0080);
    end
    rd_chk(wesp_pkg::OFS_IRQ_STATUS, 32'h0000_0002, 32'h0000_0002);
    rd_chk(wesp_pkg::OFS_READY_STATUS, 32'h0000_0003, 32'h0000_0002);
    wr(wesp_pkg::OFS_IF_CONFIG, 32'h0000_002E);
    clk_rate(50);
    wr(wesp_pkg::OFS_DATA_HIGH, 32'h0000_005A);
    wr(wesp_pkg::OFS_DATA_LOW_TRIG, 32'h0000_00A5);
    wait_done;
    chk({16'h0000, last_word}, 32'h0000_A55A);
    // park the external clock low, then flip the output polarity
    ext_run <= 1'b0;
    repeat (8) @(posedge clk);
    chk({31'h0000_0000, o_if_clk}, 32'h0000_0000);
    wr(wesp_pkg::OFS_IF_CONFIG, 32'h0000_003E);
    chk({31'h0000_0000, o_if_clk}, 32'h0000_0001);
    wr(wesp_pkg::OFS_IF_CONFIG, 32'h0000_0025);
    wr(wesp_pkg::OFS_DATA_LOW_TRIG, 32'h0000_0011);
    rd_chk(wesp_pkg::OFS_TRIGGER, 32'h0000_0080, 32'h0000_0080);
    chk({15'h0000, o_port_mode, last_word}, 32'h0001_A55A);
    conclude;
  end
endmodule // tb_top
`default_nettype wire
